// *** core/xsa_alu.sv ***
// Single-cycle XOR, subtract and nibble-swap datapath with its own flags.
`timescale 1ns/1ps
// Notes on behaviour
// - Literal XOR into accumulator, zero flag only.
// - File minus accumulator; carry, digit carry, zero.
// - Subtract result goes where destination bit says.
// - File XOR with accumulator, zero flag only.
// - File XOR result routed by destination bit.
// - Swap nibbles of file; flags untouched.
// - Swapped byte routed by destination bit.
module xsa_alu
    import xsa_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       op_valid,
    input  wire xsa_pkg::xsa_op_t           op_code,
    input  wire logic [xsa_pkg::DATA_W-1:0] op_literal,
    input  wire logic [xsa_pkg::ADDR_W-1:0] op_addr,
    input  wire logic                       op_dest,
    output logic      [xsa_pkg::ADDR_W-1:0] file_raddr,
    input  wire logic [xsa_pkg::DATA_W-1:0] file_rdata,
    output logic                            file_we,
    output logic      [xsa_pkg::ADDR_W-1:0] file_waddr,
    output logic      [xsa_pkg::DATA_W-1:0] file_wdata,
    output logic      [xsa_pkg::DATA_W-1:0] acc,
    output logic                            zero_flag,
    output logic                            carry_flag,
    output logic                            digit_carry_flag
);
    import xsa_pkg::*;

    // ========================================================================
    // Result computation
    // ========================================================================
    logic [DATA_W-1:0]  acc_ff;
    logic [DATA_W-1:0]  nxt_acc;
    logic [FLAGS_W-1:0] flags_ff;
    logic [FLAGS_W-1:0] nxt_flags;
    logic [DATA_W-1:0]  result;
    logic [DATA_W:0]    diff;
    logic [NIB_W:0]     low_diff;
    logic               to_file;

    // The file register is read combinationally so that read, operate and
    // write all fit in the one instruction cycle.
    assign file_raddr = op_addr;

    always_comb begin
        diff     = {1'b0, file_rdata} - {1'b0, acc_ff};
        low_diff = {1'b0, file_rdata[NIB_W-1:0]} - {1'b0, acc_ff[NIB_W-1:0]};
        unique case (op_code)
            XSA_OP_XOR_LIT:  result = acc_ff ^ op_literal;
            XSA_OP_SUB_FILE: result = diff[DATA_W-1:0];
            XSA_OP_XOR_FILE: result = acc_ff ^ file_rdata;
            XSA_OP_SWAP:     result = {file_rdata[NIB_W-1:0],
                                       file_rdata[DATA_W-1:NIB_W]};
        endcase
    end

    // Literal XOR always lands in the accumulator; the others obey op_dest.
    assign to_file = op_valid && (op_code != XSA_OP_XOR_LIT)
                     && (op_dest == DEST_FILE);

    // ========================================================================
    // File write port
    // ========================================================================
    // Write strobe is combinational so the write lands at the same edge that
    // would have updated the accumulator.
    assign file_we    = to_file;
    assign file_waddr = op_addr;

    // Write data comes straight from the result, not from a flop: a
    // registered copy would reach the file one cycle late.
    assign file_wdata = result;

    // ========================================================================
    // Accumulator and flags
    // ========================================================================
    // Zero test shared by every operation that updates the zero flag.
    function automatic logic is_zero(input logic [DATA_W-1:0] value);
        return value == '0;
    endfunction : is_zero

    always_comb begin
        nxt_acc   = acc_ff;
        nxt_flags = flags_ff;
        if (op_valid) begin
            if (!to_file) begin
                nxt_acc = result;
            end
            unique case (op_code)
                XSA_OP_XOR_LIT, XSA_OP_XOR_FILE: begin
                    nxt_flags[FLAG_Z] = is_zero(result);
                end
                XSA_OP_SUB_FILE: begin
                    // No borrow reads as carry set, as in most 8-bit cores.
                    nxt_flags[FLAG_C]     = ~diff[DATA_W];
                    nxt_flags[FLAG_DIGIT] = ~low_diff[NIB_W];
                    nxt_flags[FLAG_Z]     = is_zero(result);
                end
                XSA_OP_SWAP: begin
                    nxt_flags = flags_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_ff   <= ACC_RST;
            flags_ff <= FLAGS_RST;
        end else begin
            acc_ff   <= nxt_acc;
            flags_ff <= nxt_flags;
        end
    end

    assign acc              = acc_ff;
    assign zero_flag        = flags_ff[FLAG_Z];
    assign carry_flag       = flags_ff[FLAG_C];
    assign digit_carry_flag = flags_ff[FLAG_DIGIT];

    // ========================================================================
    // Checks
    // ========================================================================
    AST_XORLIT_ACC: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_LIT |=>
        acc == ($past(acc) ^ $past(op_literal)) && !$past(file_we))
        else $error("literal xor result wrong");

    AST_XORLIT_FLAGS: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_LIT |=>
        carry_flag == $past(carry_flag)
        && digit_carry_flag == $past(digit_carry_flag)
        && zero_flag == (acc == 8'h00))
        else $error("literal xor flags wrong");

    AST_SUB_FLAGS: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SUB_FILE |=>
        carry_flag == ($past(file_rdata) >= $past(acc))
        && zero_flag == ($past(file_rdata) == $past(acc)))
        else $error("subtract flags wrong");

    AST_SUB_DEST: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SUB_FILE && op_dest == DEST_FILE |->
        file_we && file_wdata == file_rdata - acc ##1 acc == $past(acc))
        else $error("subtract to file wrong");

    AST_XORF_ACC: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_FILE && op_dest == DEST_ACC |=>
        acc == ($past(acc) ^ $past(file_rdata))
        && carry_flag == $past(carry_flag))
        else $error("file xor to acc wrong");

    AST_XORF_DEST: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_FILE |->
        file_we == (op_dest == DEST_FILE))
        else $error("file xor routing wrong");

    AST_SWAP_DATA: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SWAP |->
        file_wdata[3:0] == file_rdata[7:4]
        && file_wdata[7:4] == file_rdata[3:0]
        ##1 $stable(zero_flag) && $stable(carry_flag))
        else $error("swap result or flags wrong");

    AST_SWAP_ACC: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SWAP && op_dest == DEST_ACC |=>
        acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap to acc wrong");

    AST_IDLE_HOLD: assert property (@(posedge clk)
        disable iff (sys_rst)
        !op_valid |-> !file_we ##1 $stable(acc) && $stable(zero_flag))
        else $error("idle cycle changed state");

    // Digit carry is the no-borrow of the low nibble on its own.
    AST_SUB_DIGIT: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SUB_FILE |=>
        digit_carry_flag == ($past(file_rdata[NIB_W-1:0])
                             >= $past(acc[NIB_W-1:0])))
        else $error("subtract digit carry wrong");

    AST_SUB_ACC: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SUB_FILE && op_dest == DEST_ACC |->
        !file_we ##1 acc == $past(file_rdata) - $past(acc))
        else $error("subtract to acc wrong");

    AST_XORF_FILE: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_FILE && op_dest == DEST_FILE |->
        file_wdata == (acc ^ file_rdata) && file_waddr == op_addr
        ##1 $stable(acc))
        else $error("file xor to file wrong");

    AST_XORF_ZERO: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_FILE |=>
        zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00)
        && digit_carry_flag == $past(digit_carry_flag))
        else $error("file xor flags wrong");

    AST_SWAP_FILE: assert property (@(posedge clk)
        disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SWAP && op_dest == DEST_FILE |->
        file_we ##1 $stable(acc) && $stable(digit_carry_flag))
        else $error("swap to file wrong");

    COV_SUB_BORROW: cover property (@(posedge clk) disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SUB_FILE ##1 !carry_flag);
    COV_XOR_ZERO: cover property (@(posedge clk) disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_LIT ##1 zero_flag);
    COV_SWAP_FILE: cover property (@(posedge clk) disable iff (sys_rst)
        op_valid && op_code == XSA_OP_SWAP && file_we);
    COV_BACK2BACK: cover property (@(posedge clk) disable iff (sys_rst)
        op_valid ##1 op_valid ##1 op_valid);
    COV_XORF_FILE: cover property (@(posedge clk) disable iff (sys_rst)
        op_valid && op_code == XSA_OP_XOR_FILE && file_we);

endmodule : xsa_alu

// *** core/xsa_pkg.sv ***
// Package of operation codes, widths and flag positions for the XSA datapath.
package xsa_pkg;

    // ========================================================================
    // Widths
    // ========================================================================
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W  = 4;

    // ========================================================================
    // Operations issued by the decoder
    // ========================================================================
    typedef enum logic [1:0] {
        XSA_OP_XOR_LIT  = 2'h0,
        XSA_OP_SUB_FILE = 2'h1,
        XSA_OP_XOR_FILE = 2'h3,
        XSA_OP_SWAP     = 2'h2
    } xsa_op_t;

    // ========================================================================
    // Destination select and status layout
    // ========================================================================
    localparam logic DEST_ACC  = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    localparam int FLAG_C     = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_Z     = 2;
    localparam int FLAGS_W    = 3;

    localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
    localparam logic [FLAGS_W-1:0] FLAGS_RST = 3'h0;

endpackage : xsa_pkg

// *** tb/xsa_file_model.sv ***
// Register file model that feeds the datapath and takes its write-backs.
`timescale 1ns/1ps
module xsa_file_model
    import xsa_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic [xsa_pkg::ADDR_W-1:0] file_raddr,
    output logic      [xsa_pkg::DATA_W-1:0] file_rdata,
    input  wire logic                       file_we,
    input  wire logic [xsa_pkg::ADDR_W-1:0] file_waddr,
    input  wire logic [xsa_pkg::DATA_W-1:0] file_wdata
);
    logic [DATA_W-1:0] mem [0:127];

    // Reads are combinational because the datapath uses them in-cycle.
    assign file_rdata = mem[file_raddr];

    always @(posedge clk) begin
        if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
    end
endmodule : xsa_file_model

// *** tb/xor_subtract_swap_alu_test.sv ***
// Directed bench for the XSA datapath against a register file model.
`timescale 1ns/1ps
module xor_subtract_swap_alu_test;
    import xsa_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    xsa_op_t op_code = XSA_OP_XOR_LIT;
    logic [7:0] op_literal = 8'h00;
    logic [6:0] op_addr = 7'h00;
    logic op_dest = 1'b0;
    logic [6:0] file_raddr, file_waddr;
    logic [7:0] file_rdata, file_wdata, acc;
    logic file_we, zero_flag, carry_flag, digit_carry_flag;
    int err_total = 0;
    int total_checks = 0;

    xsa_alu dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .op_literal(op_literal), .op_addr(op_addr),
        .op_dest(op_dest), .file_raddr(file_raddr), .file_rdata(file_rdata),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
        .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag));
    xsa_file_model fm (.clk(clk), .file_raddr(file_raddr),
        .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata));

    initial begin
        forever #25 clk = ~clk;
    end

    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Flags packed as zero, carry, digit carry in bits 2..0.
    function automatic logic [7:0] flg();
        return {5'h00, zero_flag, carry_flag, digit_carry_flag};
    endfunction : flg

    // Leaves op_valid high so that consecutive calls issue back to back.
    task automatic op(input xsa_op_t c, input logic [7:0] k,
                      input logic [6:0] a, input logic d);
        op_valid = 1'b1;
        op_code = c;
        op_literal = k;
        op_addr = a;
        op_dest = d;
        @(posedge clk);
        #1;
    endtask : op

    task automatic idle();
        op_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_sub();
        op(XSA_OP_XOR_LIT, 8'h03, 7'h00, 1'b1);
        chk(fm.mem[0], 8'h10);
        chk(acc, 8'h03);
        op(XSA_OP_SUB_FILE, 8'h00, 7'h7F, 1'b0);
        chk(acc, 8'h02);
        chk(flg(), 8'h03);
        chk(fm.mem[127], 8'h05);
        op(XSA_OP_SUB_FILE, 8'h00, 7'h7F, 1'b1);
        chk(fm.mem[127], 8'h03);
        chk(acc, 8'h02);
        op(XSA_OP_SUB_FILE, 8'h00, 7'h00, 1'b0);
        chk(flg(), 8'h02);
        op(XSA_OP_SUB_FILE, 8'h00, 7'h04, 1'b0);
        chk(acc, 8'hF4);
        chk(flg(), 8'h00);
        op(XSA_OP_SUB_FILE, 8'h00, 7'h03, 1'b0);
        chk(flg(), 8'h07);
    endtask : t_sub

    task automatic t_xor();
        op(XSA_OP_XOR_LIT, 8'h3C, 7'h00, 1'b0);
        chk(flg(), 8'h03);
        op(XSA_OP_XOR_FILE, 8'h00, 7'h01, 1'b1);
        chk(fm.mem[1], 8'hCC);
        chk(acc, 8'h3C);
        op(XSA_OP_XOR_FILE, 8'h00, 7'h01, 1'b0);
        chk(acc, 8'hF0);
        op(XSA_OP_XOR_LIT, 8'hF0, 7'h00, 1'b0);
        chk(flg(), 8'h07);
    endtask : t_xor

    task automatic t_swap();
        op(XSA_OP_SWAP, 8'h00, 7'h02, 1'b0);
        chk(acc, 8'h5A);
        chk(flg(), 8'h07);
        chk(fm.mem[2], 8'hA5);
        op(XSA_OP_SWAP, 8'h00, 7'h02, 1'b1);
        chk(fm.mem[2], 8'h5A);
        idle();
        chk(acc, 8'h5A);
        sys_rst = 1'b1;
        idle();
        sys_rst = 1'b0;
        chk(acc, 8'h00);
        chk(flg(), 8'h00);
    endtask : t_swap

    initial begin
        fm.mem[0] = 8'h10;
        fm.mem[1] = 8'hF0;
        fm.mem[2] = 8'hA5;
        fm.mem[3] = 8'hF4;
        fm.mem[4] = 8'h02;
        fm.mem[127] = 8'h05;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_sub();
        t_xor();
        t_swap();
        test_done();
    end
endmodule : xor_subtract_swap_alu_test
